/* File: dpr_defines.vh */
// Constants shared by the dual-port memory block: register map, fields, codes.
//
// Summary of operation
// - Per port: address, lane mask, direction, data.
// - Independent mode: each port on its own strobe.
// - Independent mode: per-port enable and clear.
// - In/out mode: inputs and read data separately clocked.
// - In/out mode: separate enables and clears per side.
// - Read-enable register is never cleared by clears.
// - Read/write mode: write side captures data, address, strobe.
// - Read/write mode: read side registers address, strobe, data.
// - Read/write mode: separate enables and clears per side.
// - Single-port mode: one read or write per strobe.
// - Single-port mode hosts two independent half-size memories.
// - Direction select high writes, low reads.
// - Lane written when write and mask bit high.
`ifndef DPR_DEFINES_VH
`define DPR_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define DPR_OFF_CTRL 4'h0
`define DPR_OFF_STATUS 4'h4

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define DPR_CTRL_MODE_LO 0
`define DPR_CTRL_MODE_HI 1
`define DPR_CTRL_MASK_EN 2
`define DPR_RST_MODE 2'h0
`define DPR_RST_MASK_EN 1'h0
`define DPR_ST_PEND_A 0
`define DPR_ST_PEND_B 1
`define DPR_ST_COLL 2

// ----------------------------------------------------------------------
// Clocking mode codes.
// ----------------------------------------------------------------------
`define DPR_MODE_INDEP 2'h0
`define DPR_MODE_INOUT 2'h1
`define DPR_MODE_RDWR 2'h2
`define DPR_MODE_SINGLE 2'h3

// ----------------------------------------------------------------------
// AXI4-Lite response codes.
// ----------------------------------------------------------------------
`define DPR_RESP_OKAY 2'h0
`define DPR_RESP_SLVERR 2'h2

`endif

/* File: dpr_mem.v */
// Lane-sliced two-port storage array with registered read data.
module dpr_mem #(
  parameter ADDR_W = 16,
  parameter LANES = 8,
  parameter LANE_W = 9
) (
  // Clock and synchronous reset of the read registers.
  input wire clk,
  input wire srst_n,
  // Port A access.
  input wire we_a,
  input wire re_a,
  input wire [ADDR_W-1:0] addr_a,
  input wire [LANES-1:0] lane_a,
  input wire [LANES*LANE_W-1:0] wdata_a,
  output wire [LANES*LANE_W-1:0] rdata_a,
  // Port B access.
  input wire we_b,
  input wire re_b,
  input wire [ADDR_W-1:0] addr_b,
  input wire [LANES-1:0] lane_b,
  input wire [LANES*LANE_W-1:0] wdata_b,
  output wire [LANES*LANE_W-1:0] rdata_b
);

  localparam DEPTH = 1 << ADDR_W;

  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      // One narrow array per lane, so lane masking needs no read-modify-write.
      reg [LANE_W-1:0] arr [0:DEPTH-1];
      reg [LANE_W-1:0] rq_a; // Lane read register, port A.
      reg [LANE_W-1:0] rq_b; // Lane read register, port B.

      // ----------------------------------------------------------------
      // Writes and reads; port A is written last so it wins a clash.
      // ----------------------------------------------------------------
      always @(posedge clk) begin
        if (we_b && lane_b[l]) begin
          arr[addr_b] <= wdata_b[l*LANE_W +: LANE_W];
        end
        if (we_a && lane_a[l]) begin
          arr[addr_a] <= wdata_a[l*LANE_W +: LANE_W];
        end
      end

      // Read registers hold their value between reads.
      always @(posedge clk) begin
        if (!srst_n) begin
          rq_a <= {LANE_W{1'b0}};
          rq_b <= {LANE_W{1'b0}};
        end else begin
          if (re_a) begin
            rq_a <= arr[addr_a];
          end
          if (re_b) begin
            rq_b <= arr[addr_b];
          end
        end
      end

      assign rdata_a[l*LANE_W +: LANE_W] = rq_a;
      assign rdata_b[l*LANE_W +: LANE_W] = rq_b;
    end
  endgenerate

endmodule // dpr_mem

/* File: dpr_top.v */
// Two-port memory block with selectable clocking modes and an AXI4-Lite control slave.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`include "dpr_defines.vh"

module dpr_top #(
  parameter ADDR_W = 16,
  parameter LANES = 8,
  parameter LANE_W = 9
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address channel.
  input wire awvalid,
  output reg awready,
  input wire [3:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data channel.
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response channel.
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address channel.
  input wire arvalid,
  output reg arready,
  input wire [3:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data channel.
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Port A user side.
  input wire a_in_tick,
  input wire a_in_en,
  input wire a_in_clr,
  input wire a_out_tick,
  input wire a_out_en,
  input wire a_out_clr,
  input wire [ADDR_W-1:0] a_addr,
  input wire [LANES-1:0] a_mask,
  input wire a_wr,
  input wire [LANES*LANE_W-1:0] a_wdata,
  output wire [LANES*LANE_W-1:0] a_rdata,
  // Port B user side.
  input wire b_in_tick,
  input wire b_in_en,
  input wire b_in_clr,
  input wire b_out_tick,
  input wire b_out_en,
  input wire b_out_clr,
  input wire [ADDR_W-1:0] b_addr,
  input wire [LANES-1:0] b_mask,
  input wire b_wr,
  input wire b_rden,
  input wire [LANES*LANE_W-1:0] b_wdata,
  output wire [LANES*LANE_W-1:0] b_rdata
);

  localparam DATA_W = LANES * LANE_W; // Eight groups of nine at the default.

  // ----------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------
  reg [1:0] mode; // Clocking mode code.
  reg mask_en; // Low means every lane is written, as with masks left high.
  reg coll; // Sticky: both ports wrote one address in one cycle.

  // Packed per-port views of the user pins; index 0 is A, 1 is B.
  wire [1:0] in_tick = {b_in_tick, a_in_tick};
  wire [1:0] in_en = {b_in_en, a_in_en};
  wire [1:0] in_clr = {b_in_clr, a_in_clr};
  wire [1:0] out_tick = {b_out_tick, a_out_tick};
  wire [1:0] out_en = {b_out_en, a_out_en};
  wire [1:0] out_clr = {b_out_clr, a_out_clr};
  wire [1:0] wr_in = {b_wr, a_wr};
  wire [2*ADDR_W-1:0] addr_in = {b_addr, a_addr};
  wire [2*LANES-1:0] mask_in = {b_mask, a_mask};
  wire [2*DATA_W-1:0] wdata_in = {b_wdata, a_wdata};

  // Per-port results of the generate loop.
  wire [1:0] we; // Array write strobe.
  wire [1:0] re; // Array read strobe.
  wire [1:0] pend; // Captured request awaiting the array.
  wire [2*ADDR_W-1:0] acc_addr; // Captured address.
  wire [2*LANES-1:0] acc_lane; // Effective lane enables.
  wire [2*DATA_W-1:0] acc_wdata; // Captured write data.
  wire [2*DATA_W-1:0] arr_rdata; // Registered array read data.
  wire [2*DATA_W-1:0] out_q; // Port output registers.

  assign a_rdata = out_q[DATA_W-1:0];
  assign b_rdata = out_q[2*DATA_W-1:DATA_W];

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      reg pend_q; // Request captured, array access next cycle.
      reg wr_q; // Captured direction: write.
      reg rd_q; // Captured read strobe; for port B in read/write mode, the rden register.
      reg [ADDR_W-1:0] addr_q;
      reg [LANES-1:0] mask_q;
      reg [DATA_W-1:0] wdata_q;
      reg rv_q; // Array read data became fresh this cycle.
      reg [DATA_W-1:0] dout_q;
      wire cap = in_tick[p] & in_en[p]; // Input-side register load.
      wire rw_mode = (mode == `DPR_MODE_RDWR);
      wire sp_mode = (mode == `DPR_MODE_SINGLE);
      wire io_mode = (mode == `DPR_MODE_INOUT);
      // Port A is the write side and port B the read side in read/write mode.
      wire wr_ok = rw_mode ? ((p == 0) & wr_in[p]) : wr_in[p];
      wire rd_ok = rw_mode ? ((p == 1) & b_rden) : ~wr_in[p];
      wire [ADDR_W-1:0] a_raw = addr_in[p*ADDR_W +: ADDR_W];
      // Single-port mode pins each port to its own half of the array.
      wire [ADDR_W-1:0] a_eff = sp_mode ? {(p == 1), a_raw[ADDR_W-2:0]} : a_raw;
      // Output side follows its own strobe only in in/out mode.
      wire out_load = io_mode ? (out_tick[p] & out_en[p]) : rv_q;
      wire out_wipe = io_mode ? out_clr[p] : in_clr[p];

      // --------------------------------------------------------------------
      // Input-side registers: each port loads only on its own strobe.
      // --------------------------------------------------------------------
      always @(posedge aclk) begin
        if (!aresetn) begin
          pend_q <= 1'b0;
          wr_q <= 1'b0;
          addr_q <= {ADDR_W{1'b0}};
          mask_q <= {LANES{1'b0}};
          wdata_q <= {DATA_W{1'b0}};
        end else if (in_clr[p]) begin
          pend_q <= 1'b0;
          wr_q <= 1'b0;
          addr_q <= {ADDR_W{1'b0}};
          mask_q <= {LANES{1'b0}};
          wdata_q <= {DATA_W{1'b0}};
        end else if (cap) begin
          pend_q <= 1'b1;
          wr_q <= wr_ok;
          addr_q <= a_eff;
          mask_q <= mask_in[p*LANES +: LANES];
          wdata_q <= wdata_in[p*DATA_W +: DATA_W];
        end else begin
          pend_q <= 1'b0; // One array access per captured request.
        end
      end

      // The read strobe register has no clear: only reset or a load changes it.
      always @(posedge aclk) begin
        if (!aresetn) begin
          rd_q <= 1'b0;
        end else if (cap) begin
          rd_q <= rd_ok;
        end
      end

      // --------------------------------------------------------------------
      // Output register; a clear beats a simultaneous load.
      // --------------------------------------------------------------------
      always @(posedge aclk) begin
        if (!aresetn) begin
          rv_q <= 1'b0;
          dout_q <= {DATA_W{1'b0}};
        end else begin
          rv_q <= re[p] & ~in_clr[p];
          if (out_wipe) begin
            dout_q <= {DATA_W{1'b0}};
          end else if (out_load) begin
            dout_q <= arr_rdata[p*DATA_W +: DATA_W];
          end
        end
      end

      // A write never also reads, so each strobe does one thing.
      assign we[p] = pend_q & wr_q;
      assign re[p] = pend_q & ~wr_q & rd_q;
      assign pend[p] = pend_q;
      assign acc_addr[p*ADDR_W +: ADDR_W] = addr_q;
      assign acc_lane[p*LANES +: LANES] = mask_en ? mask_q : {LANES{1'b1}};
      assign acc_wdata[p*DATA_W +: DATA_W] = wdata_q;
      assign out_q[p*DATA_W +: DATA_W] = dout_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Storage array.
  // ----------------------------------------------------------------------
  dpr_mem #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk(aclk),
    .srst_n(aresetn),
    .we_a(we[0]),
    .re_a(re[0]),
    .addr_a(acc_addr[ADDR_W-1:0]),
    .lane_a(acc_lane[LANES-1:0]),
    .wdata_a(acc_wdata[DATA_W-1:0]),
    .rdata_a(arr_rdata[DATA_W-1:0]),
    .we_b(we[1]),
    .re_b(re[1]),
    .addr_b(acc_addr[2*ADDR_W-1:ADDR_W]),
    .lane_b(acc_lane[2*LANES-1:LANES]),
    .wdata_b(acc_wdata[2*DATA_W-1:DATA_W]),
    .rdata_b(arr_rdata[2*DATA_W-1:DATA_W])
  );

  // ----------------------------------------------------------------------
  // AXI4-Lite write path.
  // ----------------------------------------------------------------------
  reg aw_held; // Write address taken, waiting for data.
  reg w_held; // Write data taken, waiting for address.
  reg [3:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire do_wr = aw_held & w_held & ~bvalid; // Both halves present, response free.
  wire clash = we[0] & we[1] & (acc_addr[ADDR_W-1:0] == acc_addr[2*ADDR_W-1:ADDR_W]);
  wire coll_clr = do_wr & (aw_q == `DPR_OFF_STATUS) & ws_q[0] & w_q[`DPR_ST_COLL];

  // Address and data are accepted independently, in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `DPR_RESP_OKAY;
      mode <= `DPR_RST_MODE;
      mask_en <= `DPR_RST_MASK_EN;
    end else begin
      awready <= ~aw_held & ~aw_take;
      wready <= ~w_held & ~w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_q <= wdata;
        ws_q <= wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        case (aw_q)
          `DPR_OFF_CTRL: begin
            bresp <= `DPR_RESP_OKAY;
            if (ws_q[0]) begin
              mode <= w_q[`DPR_CTRL_MODE_HI:`DPR_CTRL_MODE_LO];
              mask_en <= w_q[`DPR_CTRL_MASK_EN];
            end
          end
          `DPR_OFF_STATUS: begin
            bresp <= `DPR_RESP_OKAY; // Write one to clear the collision flag.
          end
          default: begin
            bresp <= `DPR_RESP_SLVERR; // Unmapped address.
          end
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Collision flag: a new clash wins over a clear in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      coll <= 1'b0;
    end else if (clash) begin
      coll <= 1'b1;
    end else if (coll_clr) begin
      coll <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path.
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `DPR_RESP_OKAY;
    end else begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        case (araddr)
          `DPR_OFF_CTRL: begin
            rdata <= {29'h0, mask_en, mode};
            rresp <= `DPR_RESP_OKAY;
          end
          `DPR_OFF_STATUS: begin
            rdata <= {29'h0, coll, pend[1], pend[0]};
            rresp <= `DPR_RESP_OKAY;
          end
          default: begin
            rdata <= 32'h0;
            rresp <= `DPR_RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // dpr_top

/* File: dpr_properties.sv */
// Concurrent checks on the ports of the two-port memory block.
`include "dpr_defines.vh"
module dpr_properties #(
  parameter ADDR_W = 16,
  parameter LANES = 8,
  parameter LANE_W = 9
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Register bus.
  input wire awvalid,
  input wire awready,
  input wire [3:0] awaddr,
  input wire wvalid,
  input wire wready,
  input wire [31:0] wdata,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  // Port A user side.
  input wire a_in_tick,
  input wire a_in_en,
  input wire a_in_clr,
  input wire a_out_tick,
  input wire a_out_en,
  input wire a_out_clr,
  input wire [LANES*LANE_W-1:0] a_rdata
);
  // ------------------------------------------------------------------
  // Mode shadow.
  // ------------------------------------------------------------------
  // Shadow of the mode field; it relies on address and data being offered together.
  reg [1:0] mode;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `DPR_RST_MODE;
    end else if (awvalid && awready && wvalid && wready && awaddr == `DPR_OFF_CTRL) begin
      mode <= wdata[1:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write are taken at one edge.
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // A load or clear that may move the port A output register.
  sequence s_a_cause;
    $past(a_in_tick && a_in_en, 3) || $past(a_out_tick && a_out_en) || $past(a_in_clr)
      || $past(a_out_clr);
  endsequence
  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("write response not given two cycles after the write was taken");
  a_bresp_held: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before it was accepted");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not given one cycle after the address");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before it was accepted");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address accepted while read data pending");
  a_output_cause: assert property (!$stable(a_rdata) |-> s_a_cause)
    else $error("port A output moved without a load or clear");
  a_outclr_zero: assert property (mode == `DPR_MODE_INOUT && a_out_clr |=> a_rdata == '0)
    else $error("port A output clear ignored in in/out mode");
  a_inclr_zero: assert property (mode != `DPR_MODE_INOUT && a_in_clr |=> a_rdata == '0)
    else $error("port A clear ignored");
  a_rdwr_quiet: assert property (mode == `DPR_MODE_RDWR && !a_in_clr |=> $stable(a_rdata))
    else $error("port A output moved in read/write mode");
endmodule // dpr_properties

bind dpr_top dpr_properties #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) dpr_properties_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .a_in_tick(a_in_tick), .a_in_en(a_in_en), .a_in_clr(a_in_clr), .a_out_tick(a_out_tick),
  .a_out_en(a_out_en), .a_out_clr(a_out_clr), .a_rdata(a_rdata));

/* File: dpr_user.sv */
// Behavioural user logic that drives the user side of both memory ports.
module dpr_user #(
  parameter ADDR_W = 8
) (
  // Clock.
  input wire aclk,
  // Per-port strobes and clears; index 0 is port A, index 1 is port B.
  output logic [1:0] in_tick,
  output logic [1:0] in_en,
  output logic [1:0] clr,
  output logic [1:0] out_tick,
  output logic [1:0] out_en,
  output logic [1:0] out_clr,
  output logic [1:0] wr,
  output logic rden,
  // Per-port address, lane mask and write data.
  output logic [ADDR_W-1:0] addr [2],
  output logic [7:0] mask [2],
  output logic [71:0] wdata [2]
);
  // Quiet at time zero; enables idle high so only strobes matter.
  initial begin
    in_tick = '0;
    in_en = '1;
    clr = '0;
    out_tick = '0;
    out_en = '1;
    out_clr = '0;
    wr = '0;
    rden = 1'b0;
    addr = '{default: '0};
    mask = '{default: '1};
    wdata = '{default: '0};
  end
  // One request per strobe, held through the edge that takes it.
  task automatic op(input int p, input logic w, input logic [ADDR_W-1:0] a,
                    input logic [7:0] m, input logic [71:0] d, input logic en);
    @(posedge aclk);
    in_tick[p] <= 1'b1;
    in_en[p] <= en;
    wr[p] <= w;
    if (p == 1) begin
      rden <= !w;
    end
    addr[p] <= a;
    mask[p] <= m;
    wdata[p] <= d;
    @(posedge aclk);
    in_tick[p] <= 1'b0;
    in_en[p] <= 1'b1;
    if (p == 1) begin
      rden <= 1'b0;
    end
    // Released lines show the inverse so a stale copy can never look right.
    addr[p] <= ~a;
    wdata[p] <= ~d;
  endtask
  // One-cycle pulse: kind 0 loads the output, 1 clears inputs, 2 clears the output,
  // 3 strobes the output with its enable low.
  task automatic pulse(input int p, input int k);
    @(posedge aclk);
    case (k)
      0: out_tick[p] <= 1'b1;
      1: clr[p] <= 1'b1;
      3: begin
        out_tick[p] <= 1'b1;
        out_en[p] <= 1'b0;
      end
      default: out_clr[p] <= 1'b1;
    endcase
    @(posedge aclk);
    out_tick[p] <= 1'b0;
    out_en[p] <= 1'b1;
    clr[p] <= 1'b0;
    out_clr[p] <= 1'b0;
  endtask
endmodule // dpr_user

/* File: tb_dpr_top.sv */
// Self-checking bench for the two-port memory block.
`include "dpr_defines.vh"
module tb_dpr_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 8;
  localparam logic [71:0] D1 = 72'h123456789ABCDEF012;
  localparam logic [71:0] D2 = 72'hFEDCBA9876543210FE;
  localparam logic [71:0] D3 = 72'h0F0F0F0F0F0F0F0F0F;
  localparam logic [71:0] D4 = 72'hA5A5A5A5A5A5A5A5A5;
  localparam logic [71:0] MIX = {D2[71:36], D1[35:0]};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata;
  wire awready, wready, bvalid, arready, rvalid, rden;
  wire [1:0] bresp, rresp, in_tick, in_en, clr, out_tick, out_clr, wr, out_en;
  wire [31:0] rdata;
  wire [71:0] a_rdata, b_rdata;
  wire [AW-1:0] addr [2];
  wire [7:0] mask [2];
  wire [71:0] udata [2];
  int bad_count, checked;
  dpr_user #(.ADDR_W(AW)) dpr_user_i (.aclk(aclk), .in_tick(in_tick), .in_en(in_en), .clr(clr),
    .out_tick(out_tick), .out_clr(out_clr), .wr(wr), .rden(rden), .addr(addr), .mask(mask),
    .out_en(out_en), .wdata(udata));
  dpr_top #(.ADDR_W(AW)) dpr_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .a_in_tick(in_tick[0]), .a_in_en(in_en[0]),
    .a_in_clr(clr[0]), .a_out_tick(out_tick[0]), .a_out_en(out_en[0]), .a_out_clr(out_clr[0]),
    .a_addr(addr[0]), .a_mask(mask[0]), .a_wr(wr[0]), .a_wdata(udata[0]), .a_rdata(a_rdata),
    .b_in_tick(in_tick[1]), .b_in_en(in_en[1]), .b_in_clr(clr[1]), .b_out_tick(out_tick[1]),
    .b_out_en(out_en[1]), .b_out_clr(out_clr[1]), .b_addr(addr[1]), .b_mask(mask[1]),
    .b_wr(wr[1]), .b_rden(rden), .b_wdata(udata[1]), .b_rdata(b_rdata));
  // 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Counts one comparison and reports it at once if it fails.
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bus write: each half is released once taken, then the response is awaited.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa = 1'b1;
    logic pw = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk(bresp === er, "write response code");
  endtask
  // Bus read: address held until taken, data taken at the edge rvalid is seen.
  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata === ed && rresp === er, "read data or response");
  endtask
  // Sets clocking mode and lane-mask use.
  task automatic set_ctrl(input logic [1:0] md, input logic men);
    axi_write(`DPR_OFF_CTRL, {29'h0, men, md}, `DPR_RESP_OKAY);
  endtask
  // Reads a word on port p; the output register loads two edges after the strobe.
  task automatic rd(input int p, input logic [AW-1:0] a, input logic [71:0] e, input string s);
    dpr_user_i.op(p, 1'b0, a, 8'hFF, 72'h0, 1'b1);
    repeat (2) @(posedge aclk);
    #1;
    chk((p == 1 ? b_rdata : a_rdata) === e, s);
  endtask
  // Reset values, readback and an unmapped address.
  task automatic t_regs();
    axi_read(`DPR_OFF_CTRL, 32'h0, `DPR_RESP_OKAY);
    axi_read(`DPR_OFF_STATUS, 32'h0, `DPR_RESP_OKAY);
    axi_write(`DPR_OFF_CTRL, 32'h5, `DPR_RESP_OKAY);
    axi_read(`DPR_OFF_CTRL, 32'h5, `DPR_RESP_OKAY);
    axi_write(4'h8, 32'h7, `DPR_RESP_SLVERR);
    axi_read(4'h8, 32'h0, `DPR_RESP_SLVERR);
  endtask
  // Independent ports, writes that do not read, lane masks and a disabled strobe.
  task automatic t_indep();
    set_ctrl(`DPR_MODE_INDEP, 1'b0);
    dpr_user_i.op(0, 1'b1, 8'h03, 8'h00, D1, 1'b1);
    rd(1, 8'h03, D1, "port B sees port A write");
    rd(0, 8'h03, D1, "port A read back");
    dpr_user_i.op(0, 1'b1, 8'h03, 8'hFF, D2, 1'b1);
    repeat (2) @(posedge aclk);
    #1 chk(a_rdata === D1, "write disturbed read data");
    set_ctrl(`DPR_MODE_INDEP, 1'b1);
    dpr_user_i.op(0, 1'b1, 8'h03, 8'h0F, D1, 1'b1);
    dpr_user_i.op(0, 1'b1, 8'h03, 8'hFF, D3, 1'b0);
    rd(1, 8'h03, MIX, "lane mask merge");
  endtask
  // Both ports write one word in one cycle: port A wins and the sticky flag rises.
  task automatic t_clash();
    fork
      dpr_user_i.op(0, 1'b1, 8'h07, 8'hFF, D3, 1'b1);
      dpr_user_i.op(1, 1'b1, 8'h07, 8'hFF, D4, 1'b1);
    join
    axi_read(`DPR_OFF_STATUS, 32'h4, `DPR_RESP_OKAY);
    axi_write(`DPR_OFF_STATUS, 32'h4, `DPR_RESP_OKAY);
    axi_read(`DPR_OFF_STATUS, 32'h0, `DPR_RESP_OKAY);
    rd(0, 8'h07, D3, "port A wins a clash");
  endtask
  // In/out mode: output register waits for its own strobe and has its own clear.
  task automatic t_inout();
    set_ctrl(`DPR_MODE_INOUT, 1'b0);
    dpr_user_i.op(0, 1'b0, 8'h03, 8'hFF, 72'h0, 1'b1);
    repeat (3) @(posedge aclk);
    #1 chk(a_rdata === D3, "output loaded without its strobe");
    dpr_user_i.pulse(0, 3);
    #1 chk(a_rdata === D3, "output strobe ignored its enable");
    dpr_user_i.pulse(0, 0);
    #1 chk(a_rdata === MIX, "output strobe load");
    dpr_user_i.pulse(0, 2);
    #1 chk(a_rdata === 72'h0 && b_rdata === MIX, "output clear");
  endtask
  // Read/write mode: A writes, B reads with its read strobe, B writes are dropped.
  task automatic t_rdwr();
    set_ctrl(`DPR_MODE_RDWR, 1'b0);
    dpr_user_i.op(0, 1'b1, 8'h05, 8'hFF, D1, 1'b1);
    dpr_user_i.op(1, 1'b1, 8'h05, 8'hFF, D2, 1'b1);
    rd(1, 8'h05, D1, "read side output");
    rd(0, 8'h05, 72'h0, "write side does not read");
  endtask
  // Single-port mode: two separate memories, then a port A clear in independent mode.
  task automatic t_single();
    set_ctrl(`DPR_MODE_SINGLE, 1'b0);
    dpr_user_i.op(0, 1'b1, 8'h05, 8'hFF, D3, 1'b1);
    dpr_user_i.op(1, 1'b1, 8'h05, 8'hFF, D4, 1'b1);
    rd(0, 8'h05, D3, "lower memory");
    rd(1, 8'h05, D4, "upper memory");
    set_ctrl(`DPR_MODE_INDEP, 1'b0);
    rd(1, 8'h85, D4, "upper memory seen from port B");
    dpr_user_i.pulse(0, 1);
    #1 chk(a_rdata === 72'h0 && b_rdata === D4, "port A clear");
  endtask
  // Main sequence: reset for 16 cycles, then every scenario.
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_indep();
    t_clash();
    t_inout();
    t_rdwr();
    t_single();
    report_and_stop();
  end
  // Watchdog: the scenarios need well under 1000 cycles.
  initial begin
    #50us;
    bad_count++;
    report_and_stop();
  end
endmodule // tb_dpr_top
